// >>> hw/sdi_params.svh
// register offsets, field positions, reset values and timing counts
// assumes inclusion by the digital input unit and its package users
`ifndef SDI_PARAMS_SVH
`define SDI_PARAMS_SVH

`define SDI_ADDR_W        8
`define SDI_OFF_IN_LO     8'h88
`define SDI_OFF_IN_HI     8'h89
`define SDI_OFF_RISE_LO   8'h90
`define SDI_OFF_RISE_HI   8'h91
`define SDI_OFF_FALL_LO   8'h92
`define SDI_OFF_FALL_HI   8'h93
`define SDI_OFF_DELAY     8'h94
`define SDI_OFF_STAT_LO   8'h98
`define SDI_OFF_STAT_HI   8'h99
`define SDI_OFF_LOST_LO   8'h9a
`define SDI_OFF_LOST_HI   8'h9b
`define SDI_OFF_DIAG      8'h9c
`define SDI_OFF_IEN_DIAG  8'h9d
`define SDI_OFF_CLR_LO    8'ha0
`define SDI_OFF_CLR_HI    8'ha1
`define SDI_OFF_CLR_DIAG  8'ha2

`define SDI_DIAG_LOST_BIT 0
`define SDI_DELAY_RESET   8'h00
`define SDI_EDGE_EN_RESET 8'h00

// delays in microseconds, clock in MHz
`define SDI_CLK_MHZ       100
`define SDI_DLY0_US       100
`define SDI_DLY1_US       500
`define SDI_DLY2_US       3000
`define SDI_DLY3_US       15000
`define SDI_DLY0_CYC      (`SDI_DLY0_US * `SDI_CLK_MHZ)
`define SDI_DLY1_CYC      (`SDI_DLY1_US * `SDI_CLK_MHZ)
`define SDI_DLY2_CYC      (`SDI_DLY2_US * `SDI_CLK_MHZ)
`define SDI_DLY3_CYC      (`SDI_DLY3_US * `SDI_CLK_MHZ)

`endif

// >>> hw/sdi_pkg.sv
// types shared by the digital input unit
// assumes sdi_params.svh alongside
package sdi_pkg;
  typedef logic [1:0] sdi_dly_sel_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } sdi_bus_req_s;
  typedef struct packed {
    logic [3:0] trk_a;
    logic [3:0] trk_b;
    logic [3:0] freq;
    logic       gate3;
    logic       latch3;
  } sdi_cnt_tap_s;
  typedef enum logic [1:0] {
    SDI_ST_IDLE = 2'b00,
    SDI_ST_WAIT = 2'b01
  } sdi_flt_e;
endpackage : sdi_pkg

// >>> hw/sdi_filter.sv
// one debounce channel: accepts a change only after it has been stable
// assumes a synchronised input and a delay count in clock cycles
`timescale 1ns/1ns
module sdi_filter
  import sdi_pkg::*;
#(
  parameter int CNT_W = 21
) (
  input  wire logic             mclk,
  input  wire logic             reset_n,
  input  wire logic             sync_in,
  input  wire logic [CNT_W-1:0] dly_cyc,
  output logic                  filt_out
);
  if (CNT_W < 2) begin : g_bad_cnt_w
    $error("sdi_filter: CNT_W too small");
  end

  sdi_flt_e         st_ff, nxt_st;
  logic [CNT_W-1:0] cnt_ff, nxt_cnt;
  logic             val_ff, nxt_val;

  always_comb begin
    nxt_st  = st_ff;
    nxt_cnt = cnt_ff;
    nxt_val = val_ff;
    case (st_ff)
      SDI_ST_IDLE: begin
        if (sync_in != val_ff) begin
          nxt_st  = SDI_ST_WAIT;
          nxt_cnt = CNT_W'(1);
        end
      end
      SDI_ST_WAIT: begin
        // R8 stable for delay
        if (sync_in == val_ff) begin
          nxt_st = SDI_ST_IDLE;
        end else if (cnt_ff >= dly_cyc) begin
          nxt_val = sync_in;
          nxt_st  = SDI_ST_IDLE;
        end else begin
          nxt_cnt = cnt_ff + CNT_W'(1);
        end
      end
      default: nxt_st = SDI_ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      st_ff  <= SDI_ST_IDLE;
      cnt_ff <= '0;
      val_ff <= 1'b0;
    end else begin
      st_ff  <= nxt_st;
      cnt_ff <= nxt_cnt;
      val_ff <= nxt_val;
    end
  end

  assign filt_out = val_ff;
endmodule : sdi_filter

// >>> hw/sdi_digital_input.sv
// sixteen-channel digital input unit with filters, edge interrupts,
// lost-interrupt diagnostics, status lamps and counter taps
// assumes asynchronous sensor pins and a same-clock register master
`timescale 1ns/1ns
`include "sdi_params.svh"

// Summary of operation
// R1: inputs 0..7 read as one byte, bit n is input n
// R2: inputs 8..15 read as next byte, bit n is input 8+n
// R3: separate rising and falling interrupt enables per channel
// R4: all edge enables cleared by reset
// R5: rising is filtered 0 to 1, falling is 1 to 0
// R6: diagnostic interrupt only when a hardware interrupt is lost
// R7: one delay setting per group of four channels
// R8: four delays; change accepted after stable for selected delay
// R9: one green lamp per input, lit while input reads one
// R10: inputs 0,3,6 track A; 1,4,7 track B and frequency 0..2
// R11: input 9 A3, 10 B3 and freq 3, 11 gate 3, 15 latch 3
// R12: counter taps take pulses up to 100kHz, others 1kHz
// R13: edge interrupts use the filtered value, not the raw pin
module sdi_digital_input
  import sdi_pkg::*;
#(
  parameter int NCH   = 16,
  parameter int CNT_W = 21,
  parameter int DLY0  = `SDI_DLY0_CYC,
  parameter int DLY1  = `SDI_DLY1_CYC,
  parameter int DLY2  = `SDI_DLY2_CYC,
  parameter int DLY3  = `SDI_DLY3_CYC
) (
  input  wire logic             mclk,
  input  wire logic             reset_n,
  input  wire logic [NCH-1:0]   di_pin,
  input  wire logic [7:0]       reg_addr,
  input  wire logic [7:0]       reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output logic      [7:0]       reg_rdata,
  output logic                  hw_irq,
  output logic                  diag_irq,
  output logic      [NCH-1:0]   led_green,
  output logic      [NCH-1:0]   cnt_fast_in,
  output sdi_cnt_tap_s          cnt_tap
);
  // refused at elaboration: byte lanes are fixed, delays must fit the count
  if (NCH != 16) begin : g_bad_nch
    $error("sdi_digital_input: NCH must be 16");
  end
  if (CNT_W > 30 || DLY0 >= (1 << CNT_W) || DLY1 >= (1 << CNT_W) ||
      DLY2 >= (1 << CNT_W) || DLY3 >= (1 << CNT_W)) begin : g_bad_dly
    $error("sdi_digital_input: a delay does not fit CNT_W");
  end
  if (DLY0 < 1 || DLY1 < 1 || DLY2 < 1 || DLY3 < 1) begin : g_bad_min
    $error("sdi_digital_input: delay below one cycle");
  end

  logic [NCH-1:0] meta_ff, sync_ff, filt, filt_d_ff;
  logic [7:0]     rise_lo_ff, rise_hi_ff, fall_lo_ff, fall_hi_ff;
  logic [7:0]     dly_ff;
  logic [NCH-1:0] stat_ff, lost_ff, ien_ff;
  logic           diag_ff, ien_diag_ff;
  logic [7:0]     rdata_ff;
  logic [CNT_W-1:0] grp_dly [4];

  logic [7:0]     nxt_rise_lo, nxt_rise_hi, nxt_fall_lo, nxt_fall_hi;
  logic [7:0]     nxt_dly, nxt_rdata;
  logic [NCH-1:0] nxt_stat, nxt_lost, nxt_ien, nxt_filt_d;
  logic           nxt_diag, nxt_ien_diag;
  logic [NCH-1:0] rise_en, fall_en, edge_ev, clr_mask, new_lost;
  logic           wr_hit_clr_lo, wr_hit_clr_hi;

  // pins cross into mclk through two flops
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= di_pin;
      sync_ff <= meta_ff;
    end
  end

  // R7 group delay select
  always_comb begin
    for (int g = 0; g < 4; g++) begin
      case (dly_ff[2*g +: 2])
        2'd0:    grp_dly[g] = CNT_W'(DLY0);
        2'd1:    grp_dly[g] = CNT_W'(DLY1);
        2'd2:    grp_dly[g] = CNT_W'(DLY2);
        default: grp_dly[g] = CNT_W'(DLY3);
      endcase
    end
  end

  // R8 per-channel filter
  for (genvar i = 0; i < NCH; i++) begin : g_flt
    sdi_filter #(
      .CNT_W (CNT_W)
    ) u_flt (
      .mclk     (mclk),
      .reset_n  (reset_n),
      .sync_in  (sync_ff[i]),
      .dly_cyc  (grp_dly[i/4]),
      .filt_out (filt[i])
    );
  end

  assign rise_en = {rise_hi_ff, rise_lo_ff};
  assign fall_en = {fall_hi_ff, fall_lo_ff};
  assign wr_hit_clr_lo = reg_wr && (reg_addr == `SDI_OFF_CLR_LO);
  assign wr_hit_clr_hi = reg_wr && (reg_addr == `SDI_OFF_CLR_HI);
  assign clr_mask = {wr_hit_clr_hi ? reg_wdata : 8'h00,
                     wr_hit_clr_lo ? reg_wdata : 8'h00};

  always_comb begin
    nxt_filt_d = filt;
    // R13 edges of filtered value
    // R5 rising and falling
    edge_ev = (rise_en & filt & ~filt_d_ff) |
              (fall_en & ~filt & filt_d_ff);
    // R6 event on a still pending bit is lost
    new_lost = edge_ev & stat_ff & ~clr_mask;
    // set wins over clear
    nxt_stat = (stat_ff & ~clr_mask) | edge_ev;
    nxt_lost = (lost_ff & ~clr_mask) | new_lost;
    nxt_diag = diag_ff;
    if (reg_wr && reg_addr == `SDI_OFF_CLR_DIAG &&
        reg_wdata[`SDI_DIAG_LOST_BIT]) begin
      nxt_diag = 1'b0;
    end
    if (|new_lost) begin
      nxt_diag = 1'b1;
    end
  end

  // register writes
  always_comb begin
    nxt_rise_lo  = rise_lo_ff;
    nxt_rise_hi  = rise_hi_ff;
    nxt_fall_lo  = fall_lo_ff;
    nxt_fall_hi  = fall_hi_ff;
    nxt_dly      = dly_ff;
    nxt_ien      = ien_ff;
    nxt_ien_diag = ien_diag_ff;
    if (reg_wr) begin
      case (reg_addr)
        // R3 rise and fall enables
        `SDI_OFF_RISE_LO:  nxt_rise_lo  = reg_wdata;
        `SDI_OFF_RISE_HI:  nxt_rise_hi  = reg_wdata;
        `SDI_OFF_FALL_LO:  nxt_fall_lo  = reg_wdata;
        `SDI_OFF_FALL_HI:  nxt_fall_hi  = reg_wdata;
        `SDI_OFF_DELAY:    nxt_dly      = reg_wdata;
        `SDI_OFF_STAT_LO:  nxt_ien[7:0] = reg_wdata;
        `SDI_OFF_STAT_HI:  nxt_ien[15:8] = reg_wdata;
        `SDI_OFF_IEN_DIAG: nxt_ien_diag = reg_wdata[0];
        default: ;
      endcase
    end
  end

  // reads; unmapped reads return zero
  always_comb begin
    nxt_rdata = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        // R1 low byte
        `SDI_OFF_IN_LO:   nxt_rdata = filt[7:0];
        // R2 high byte
        `SDI_OFF_IN_HI:   nxt_rdata = filt[15:8];
        `SDI_OFF_RISE_LO: nxt_rdata = rise_lo_ff;
        `SDI_OFF_RISE_HI: nxt_rdata = rise_hi_ff;
        `SDI_OFF_FALL_LO: nxt_rdata = fall_lo_ff;
        `SDI_OFF_FALL_HI: nxt_rdata = fall_hi_ff;
        `SDI_OFF_DELAY:   nxt_rdata = dly_ff;
        `SDI_OFF_STAT_LO: nxt_rdata = stat_ff[7:0];
        `SDI_OFF_STAT_HI: nxt_rdata = stat_ff[15:8];
        `SDI_OFF_LOST_LO: nxt_rdata = lost_ff[7:0];
        `SDI_OFF_LOST_HI: nxt_rdata = lost_ff[15:8];
        `SDI_OFF_DIAG:    nxt_rdata = {7'h00, diag_ff};
        default:          nxt_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      // R4 enables cleared
      rise_lo_ff  <= `SDI_EDGE_EN_RESET;
      rise_hi_ff  <= `SDI_EDGE_EN_RESET;
      fall_lo_ff  <= `SDI_EDGE_EN_RESET;
      fall_hi_ff  <= `SDI_EDGE_EN_RESET;
      dly_ff      <= `SDI_DELAY_RESET;
      ien_ff      <= '0;
      ien_diag_ff <= 1'b0;
      stat_ff     <= '0;
      lost_ff     <= '0;
      diag_ff     <= 1'b0;
      filt_d_ff   <= '0;
      rdata_ff    <= 8'h00;
    end else begin
      rise_lo_ff  <= nxt_rise_lo;
      rise_hi_ff  <= nxt_rise_hi;
      fall_lo_ff  <= nxt_fall_lo;
      fall_hi_ff  <= nxt_fall_hi;
      dly_ff      <= nxt_dly;
      ien_ff      <= nxt_ien;
      ien_diag_ff <= nxt_ien_diag;
      stat_ff     <= nxt_stat;
      lost_ff     <= nxt_lost;
      diag_ff     <= nxt_diag;
      filt_d_ff   <= nxt_filt_d;
      rdata_ff    <= nxt_rdata;
    end
  end

  assign reg_rdata = rdata_ff;
  assign hw_irq    = |(stat_ff & ien_ff);
  assign diag_irq  = diag_ff & ien_diag_ff;
  // R9 lamp follows input level
  assign led_green = filt;
  // R12 fast taps bypass the debounce; slow use only via filter
  assign cnt_fast_in = sync_ff;
  // R10 counters 0..2
  // R11 counter 3 taps
  assign cnt_tap = '{
    trk_a:  {sync_ff[9], sync_ff[6], sync_ff[3], sync_ff[0]},
    trk_b:  {sync_ff[10], sync_ff[7], sync_ff[4], sync_ff[1]},
    freq:   {sync_ff[10], sync_ff[7], sync_ff[4], sync_ff[1]},
    gate3:  sync_ff[11],
    latch3: sync_ff[15]
  };
endmodule : sdi_digital_input

// >>> dv/sdi_sensor_model.sv
// sensor side: drives the sixteen input pins from a level pattern
// assumes the bench sets the pattern by non-blocking assignment
`timescale 1ns/1ns
module sdi_sensor_model (
  input  wire logic        mclk,
  input  wire logic [15:0] level,
  output logic      [15:0] di_pin
);
  // pins move one edge after the pattern, like a slow sensor output
  always_ff @(posedge mclk) begin
    di_pin <= level;
  end
endmodule : sdi_sensor_model

// >>> dv/sdi_digital_input_props.sv
// port assertions for the digital input unit
// assumes filter delays of four cycles or more
`timescale 1ns/1ns
`include "sdi_params.svh"
module sdi_digital_input_props
  import sdi_pkg::*;
#(
  parameter int NCH = 16
) (
  input wire logic           mclk,
  input wire logic           reset_n,
  input wire logic [NCH-1:0] di_pin,
  input wire logic [7:0]     reg_addr,
  input wire logic [7:0]     reg_wdata,
  input wire logic           reg_wr,
  input wire logic           reg_rd,
  input wire logic [7:0]     reg_rdata,
  input wire logic           hw_irq,
  input wire logic           diag_irq,
  input wire logic [NCH-1:0] led_green,
  input wire logic [NCH-1:0] cnt_fast_in,
  input wire sdi_cnt_tap_s   cnt_tap
);
  logic           en_seen_ff;
  logic           nxt_en_seen;
  logic [NCH-1:0] led_prev_ff;
  logic [NCH-1:0] nxt_led_prev;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // edge enables untouched since reset means no interrupt source
  always_comb begin
    nxt_en_seen  = en_seen_ff;
    nxt_led_prev = led_green;
    if (reg_wr && reg_addr >= `SDI_OFF_RISE_LO
        && reg_addr <= `SDI_OFF_FALL_HI) begin
      nxt_en_seen = 1'b1;
    end
  end
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      en_seen_ff  <= 1'b0;
      led_prev_ff <= '0;
    end else begin
      en_seen_ff  <= nxt_en_seen;
      led_prev_ff <= nxt_led_prev;
    end
  end
  track_a_map_a: assert property (
    cnt_tap.trk_a == {cnt_fast_in[9], cnt_fast_in[6], cnt_fast_in[3],
                      cnt_fast_in[0]})
    else $error("track a taps wrong");
  track_b_map_a: assert property (
    cnt_tap.trk_b == {cnt_fast_in[10], cnt_fast_in[7], cnt_fast_in[4],
                      cnt_fast_in[1]} && cnt_tap.freq == cnt_tap.trk_b)
    else $error("track b or frequency taps wrong");
  gate_latch_a: assert property (
    cnt_tap.gate3 == cnt_fast_in[11] && cnt_tap.latch3 == cnt_fast_in[15])
    else $error("gate or latch tap wrong");
  read_low_a: assert property (
    reg_rd && reg_addr == `SDI_OFF_IN_LO |=> reg_rdata == led_prev_ff[7:0])
    else $error("low input byte wrong");
  read_high_a: assert property (
    reg_rd && reg_addr == `SDI_OFF_IN_HI |=> reg_rdata == led_prev_ff[15:8])
    else $error("high input byte wrong");
  read_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside its cycle");
  // a lamp may only move to a value the pin has held for a while
  led_settle_a: assert property (
    ((led_green ^ led_prev_ff) & (led_green ^ $past(cnt_fast_in, 3))) == '0)
    else $error("input accepted before it settled");
  irq_quiet_a: assert property (!en_seen_ff |-> !hw_irq)
    else $error("interrupt with no edge enabled");
  diag_quiet_a: assert property (!en_seen_ff |-> !diag_irq)
    else $error("diagnostic with no edge enabled");
  // the two edges after reset are skipped while the flops refill
  fast_tap_sync_a: assert property (
    $past(reset_n, 2) |-> cnt_fast_in == $past(di_pin, 2))
    else $error("fast tap not two flops behind the pin");
endmodule : sdi_digital_input_props

bind sdi_digital_input sdi_digital_input_props #(.NCH(NCH)) u_props (
  .mclk, .reset_n, .di_pin, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .hw_irq, .diag_irq, .led_green, .cnt_fast_in, .cnt_tap);

// >>> dv/testbench.sv
// self-checking bench for the sixteen-channel digital input unit
// assumes filter delays shortened to 4, 8, 16 and 32 cycles
`timescale 1ns/1ns
`include "sdi_params.svh"
module testbench;
  import sdi_pkg::*;
  logic        mclk, reset_n, reg_wr, reg_rd, hw_irq, diag_irq;
  logic [15:0] level, di_pin, led_green, old;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata;
  int          n_mismatch, check_count, cyc;
  sdi_sensor_model u_sens (.mclk, .level, .di_pin);
  sdi_digital_input #(.DLY0(4), .DLY1(8), .DLY2(16), .DLY3(32)) dut (
    .mclk, .reset_n, .di_pin, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .hw_irq, .diag_irq, .led_green, .cnt_fast_in(),
    .cnt_tap());
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one idle edge after each access so a strobe is never set twice
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    @(posedge mclk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    chk({8'h00, reg_rdata}, {8'h00, exp});
    @(posedge mclk);
  endtask : rd
  task automatic irq_is(input logic h, input logic d);
    @(negedge mclk);
    chk({14'h0, hw_irq, diag_irq}, {14'h0, h, d});
    @(posedge mclk);
  endtask : irq_is
  task automatic conclude;
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : conclude
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      $display("Error at %0t: run did not finish in time", $time);
      conclude();
    end
  end
  initial begin
    {reset_n, reg_wr, reg_rd, reg_addr, reg_wdata, level} = '0;
    {n_mismatch, check_count, cyc} = '0;
    repeat (20) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    for (int a = 'h90; a <= 'h93; a++) rd(8'(a), 8'h00);
    level <= 16'ha5c3;
    repeat (60) @(posedge mclk);
    rd(`SDI_OFF_IN_LO, 8'hc3);
    rd(`SDI_OFF_IN_HI, 8'ha5);
    @(negedge mclk);
    chk(led_green, 16'ha5c3);
    @(posedge mclk);
    irq_is(1'b0, 1'b0);
    // group g gets delay code g, one channel of each group toggles
    wr(`SDI_OFF_DELAY, 8'he4);
    old = 16'ha5c3;
    level <= level ^ 16'h1111;
    for (int n = 1; n <= 40; n++) begin
      @(negedge mclk);
      for (int g = 0; g < 4; g++) begin
        if (n == (4 << g) + 2)
          chk(16'(led_green[4*g] ^ old[4*g]), 16'h0);
        if (n == (4 << g) + 8)
          chk(16'(led_green[4*g] ^ old[4*g]), 16'h1);
      end
    end
    @(posedge mclk);
    wr(`SDI_OFF_RISE_LO, 8'h01);
    wr(`SDI_OFF_FALL_LO, 8'h01);
    wr(`SDI_OFF_STAT_LO, 8'h01);
    wr(`SDI_OFF_IEN_DIAG, 8'h01);
    level[0] <= 1'b1;
    repeat (14) @(posedge mclk);
    rd(`SDI_OFF_STAT_LO, 8'h01);
    irq_is(1'b1, 1'b0);
    wr(`SDI_OFF_CLR_LO, 8'h01);
    irq_is(1'b0, 1'b0);
    // two-cycle glitch is shorter than the group delay
    level[0] <= 1'b0;
    repeat (2) @(posedge mclk);
    level[0] <= 1'b1;
    repeat (14) @(posedge mclk);
    rd(`SDI_OFF_STAT_LO, 8'h00);
    level[0] <= 1'b0;
    repeat (14) @(posedge mclk);
    rd(`SDI_OFF_STAT_LO, 8'h01);
    level[0] <= 1'b1;
    repeat (14) @(posedge mclk);
    rd(`SDI_OFF_LOST_LO, 8'h01);
    rd(`SDI_OFF_DIAG, 8'h01);
    irq_is(1'b1, 1'b1);
    wr(`SDI_OFF_STAT_LO, 8'h00);
    irq_is(1'b0, 1'b1);
    wr(`SDI_OFF_CLR_LO, 8'h01);
    wr(`SDI_OFF_CLR_DIAG, 8'h01);
    rd(`SDI_OFF_LOST_LO, 8'h00);
    irq_is(1'b0, 1'b0);
    // rising only on channel 8: its falling edge must stay silent
    wr(`SDI_OFF_RISE_HI, 8'h01);
    wr(`SDI_OFF_STAT_HI, 8'h01);
    level[8] <= 1'b1;
    repeat (30) @(posedge mclk);
    rd(`SDI_OFF_STAT_HI, 8'h01);
    irq_is(1'b1, 1'b0);
    wr(`SDI_OFF_CLR_HI, 8'h01);
    level[8] <= 1'b0;
    repeat (30) @(posedge mclk);
    rd(`SDI_OFF_STAT_HI, 8'h00);
    rd(`SDI_OFF_IN_HI, 8'hb4);
    irq_is(1'b0, 1'b0);
    wr(`SDI_OFF_IN_LO, 8'hff);
    rd(`SDI_OFF_IN_LO, 8'hd3);
    rd(8'h00, 8'h00);
    // reset mid-run with edges enabled: they must come back cleared
    reset_n <= 1'b0;
    repeat (3) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    for (int a = 'h90; a <= 'h93; a++) rd(8'(a), 8'h00);
    repeat (14) @(posedge mclk);
    rd(`SDI_OFF_STAT_LO, 8'h00);
    irq_is(1'b0, 1'b0);
    conclude();
  end
endmodule : testbench
